// ---- fss_device.sv ----
// flash self-program sequencer: latches, unlock key, control and flash sequencing
//
// Chosen here: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
module fss_device
  import fss_pkg::*;
#(
  parameter int PROG_CYC  = FSS_PROG_CYC,
  parameter int ERASE_CYC = FSS_ERASE_CYC
)(
  input  wire logic              CLOCK,
  input  wire logic              ARST_N,
  fss_link_if.device             link,
  output logic                   FLASH_PGM,
  output logic                   FLASH_ERASE,
  output logic [FSS_AW-1:0]      FLASH_ADDR,
  output logic [FSS_DW-1:0]      FLASH_DATA
);
  // sequencer: idle, table-write stall, row stream, single word, erase, flash busy
  typedef enum logic [2:0] {D_IDLE, D_TBL, D_ROW, D_WORD, D_ERASE, D_WAIT} fss_dstate_t;
  // unlock progress; open only lasts until the next link write
  typedef enum logic [1:0] {K_NONE, K_FIRST, K_OPEN} fss_key_t;

  // all sequencer state except the latches in one register so reset and update stay in one place
  typedef struct packed {
    fss_dstate_t       st;
    fss_key_t          key;
    logic              wr;
    logic              wren;
    logic              err;
    logic [3:0]        op;
    logic [15:0]       cnt;
    logic [FSS_IDX_W-1:0] idx;
    logic [FSS_AW-1:0] ptr;
    logic              stall;
    logic              pgm;
    logic              erase;
    logic [FSS_AW-1:0] faddr;
    logic [FSS_DW-1:0] fdata;
  } fss_dev_t;

  fss_dev_t r;
  fss_dev_t next_r;
  logic [FSS_DW-1:0]    latch_q;
  logic [FSS_IDX_W-1:0] rd_idx;
  logic                 tbl_take;

  // latches only load while idle; the core is stalled otherwise
  assign tbl_take = link.tbl_wr && (r.st == D_IDLE);

  // row stream walks the slots; a word program reads the pointer's slot
  assign rd_idx   = (r.st == D_ROW) ? r.idx : r.ptr[FSS_IDX_W-1:0];

  // no reset on the latches, so software pads the slots it leaves alone
  fss_latch_buf #(.WORDS(FSS_ROW_WORDS)) i_fss_latch_buf (
    .clk     (CLOCK),
    .wr_en   (tbl_take),
    .wr_idx  (link.tbl_addr[FSS_IDX_W-1:0]),
    .wr_data (link.tbl_data),
    .rd_idx  (rd_idx),
    .rd_data (latch_q)
  );

  // next-state logic for the whole sequencer
  always_comb
  begin
    next_r       = r;
    next_r.pgm   = 1'b0;
    next_r.erase = 1'b0;
    case (r.st)
      D_IDLE:
      begin
        if (tbl_take)
        begin
          // table write: latch only, flash untouched, one stall cycle
          next_r.ptr   = link.tbl_addr;
          next_r.key   = K_NONE;
          next_r.stall = 1'b1;
          next_r.cnt   = 16'(FSS_TBL_STALL);
          next_r.st    = D_TBL;
        end
        else if (link.reg_wr && link.reg_key)
        begin
          // only 55h directly followed by aah opens the lock
          if (link.reg_wdata[7:0] == FSS_KEY_SECOND && r.key == K_FIRST)
            next_r.key = K_OPEN;
          else if (link.reg_wdata[7:0] == FSS_KEY_FIRST)
            next_r.key = K_FIRST;
          // any other value, or aah without 55h just before, relocks
          else
            next_r.key = K_NONE;
        end
        // control write: fields always update, a start needs the open lock
        else if (link.reg_wr)
        begin
          next_r.wren = link.reg_wdata[FSS_WREN_BIT];
          next_r.op   = link.reg_wdata[FSS_OP_LSB +: 4];
          next_r.err  = link.reg_wdata[FSS_ERR_BIT] & r.err;
          // the lock is spent by this write whether or not it starts anything
          next_r.key  = K_NONE;
          // error only clears by software writing 0; a failed start sets it again
          if (link.reg_wdata[FSS_WR_BIT])
          begin
            if (r.key == K_OPEN && link.reg_wdata[FSS_WREN_BIT])
            begin
              next_r.wr    = 1'b1;
              next_r.stall = 1'b1;
              next_r.idx   = '0;
              case (link.reg_wdata[FSS_OP_LSB +: 4])
                FSS_OP_ROW:   next_r.st = D_ROW;
                FSS_OP_WORD:  next_r.st = D_WORD;
                FSS_OP_ERASE: next_r.st = D_ERASE;
                default:
                begin
                  // unknown operation: flag it and never stall
                  next_r.wr    = 1'b0;
                  next_r.stall = 1'b0;
                  next_r.err   = 1'b1;
                end
              endcase
            end
            else
              next_r.err = 1'b1;
          end
        end
      end
      D_TBL:
      begin
        // second cycle of the table write; the core stays held
        next_r.cnt = r.cnt - 16'h0001;
        if (r.cnt == 16'h0001)
        begin
          next_r.stall = 1'b0;
          next_r.st    = D_IDLE;
        end
      end
      D_ROW:
      begin
        // stream all latches of the row, row-aligned address
        next_r.pgm   = 1'b1;
        next_r.faddr = {r.ptr[FSS_AW-1:FSS_IDX_W], r.idx};
        next_r.fdata = latch_q;
        next_r.idx   = r.idx + 1'b1;
        // last slot sent: give the array its program time
        if (r.idx == FSS_IDX_W'(FSS_ROW_WORDS - 1))
        begin
          next_r.cnt = 16'(PROG_CYC);
          next_r.st  = D_WAIT;
        end
      end
      D_WORD:
      begin
        // one word at the pointer; the latch slot is its low bits
        next_r.pgm   = 1'b1;
        next_r.faddr = r.ptr;
        next_r.fdata = latch_q;
        next_r.cnt   = 16'(PROG_CYC);
        next_r.st    = D_WAIT;
      end
      D_ERASE:
      begin
        // one pulse clears eight rows from a 1536-byte boundary
        next_r.erase = 1'b1;
        next_r.faddr = {r.ptr[FSS_AW-1:FSS_BLK_W], {FSS_BLK_W{1'b0}}};
        next_r.cnt   = 16'(ERASE_CYC);
        next_r.st    = D_WAIT;
      end
      D_WAIT:
      begin
        // flash busy; start bit and stall fall in the same cycle
        next_r.cnt = r.cnt - 16'h0001;
        if (r.cnt == 16'h0001)
        begin
          next_r.wr    = 1'b0;
          next_r.stall = 1'b0;
          next_r.st    = D_IDLE;
        end
      end
      default:
      begin
        // an unused code after an upset falls back to idle, core released
        next_r.st    = D_IDLE;
        next_r.stall = 1'b0;
        next_r.wr    = 1'b0;
      end
    endcase
  end

  // state register; reset leaves the core running and the lock shut
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      r     <= '0;
      r.st  <= D_IDLE;
      r.key <= K_NONE;
    end
    else
      r <= next_r;
  end

  // key register is write only: readback never shows it
  assign link.ctrl_rdata = {r.wr, r.wren, r.err, 9'h000, r.op};

  // core hold straight from the register, no combinational path back
  assign link.stall      = r.stall;

  // flash strobes last one cycle per word or erase, so a row stream holds FLASH_PGM for 64; address and data keep their last value
  assign FLASH_PGM       = r.pgm;
  assign FLASH_ERASE     = r.erase;
  assign FLASH_ADDR      = r.faddr;
  assign FLASH_DATA      = r.fdata;
endmodule

// ---- fss_pkg.sv ----
// constants shared by the flash self-program sequencer ends
//
// Overview of operation
// - rows hold 64 words, 192 bytes
// - erase eight rows; program one row
// - single word program also supported
// - erase 1536-byte aligned, rows 192-byte aligned
// - table write only touches holding latch
// - any table write count; 64 fill row
// - latches have no reset value
// - software pads unused latches with all ones
// - latches load any order, last wins
// - avoid reprogramming without erase
// - table write lasts two cycles
// - one programming cycle per row
// - pointer, table writes, then control start
// - control selects operation and starts it
// - unlock key register is write only
// - keys 55h then aaH, consecutive writes
// - start bit 15, self clears at end
// - core stalled while operation runs
package fss_pkg;
  localparam int          FSS_ROW_WORDS   = 64;
  localparam int          FSS_ROW_BYTES   = 192;
  localparam int          FSS_ERASE_ROWS  = 8;
  localparam int          FSS_ERASE_WORDS = 512;
  localparam int          FSS_ERASE_BYTES = 1536;
  localparam int          FSS_AW          = 24;
  localparam int          FSS_DW          = 24;
  localparam int          FSS_IDX_W       = 6;
  localparam int          FSS_BLK_W       = 9;
  localparam logic [23:0] FSS_BLANK_WORD  = 24'hffffff;
  localparam logic [7:0]  FSS_KEY_FIRST   = 8'h55;
  localparam logic [7:0]  FSS_KEY_SECOND  = 8'haa;
  // control register fields
  localparam int          FSS_WR_BIT      = 15;
  localparam int          FSS_WREN_BIT    = 14;
  localparam int          FSS_ERR_BIT     = 13;
  localparam int          FSS_OP_LSB      = 0;
  localparam logic [3:0]  FSS_OP_ROW      = 4'h1;
  localparam logic [3:0]  FSS_OP_ERASE    = 4'h2;
  localparam logic [3:0]  FSS_OP_WORD     = 4'h3;
  localparam logic [15:0] FSS_CTRL_RESET  = 16'h0000;
  // timing in clock cycles
  localparam int          FSS_TBL_STALL   = 1;
  localparam int          FSS_PROG_CYC    = 16;
  localparam int          FSS_ERASE_CYC   = 32;
  // wishbone byte offsets of the host registers
  localparam logic [7:0]  FSS_WB_PTR      = 8'h00;
  localparam logic [7:0]  FSS_WB_DATA     = 8'h04;
  localparam logic [7:0]  FSS_WB_CTRL     = 8'h08;
  localparam logic [7:0]  FSS_WB_KEY      = 8'h0c;
  localparam logic [7:0]  FSS_WB_STAT     = 8'h10;
endpackage

// ---- fss_link_if.sv ----
// link between the processor-side host end and the sequencer device end
`timescale 1ns/1ps
interface fss_link_if;
  import fss_pkg::*;
  logic              tbl_wr;
  logic [FSS_AW-1:0] tbl_addr;
  logic [FSS_DW-1:0] tbl_data;
  logic              reg_wr;
  logic              reg_key;
  logic [15:0]       reg_wdata;
  logic [15:0]       ctrl_rdata;
  logic              stall;
  modport device (input tbl_wr, tbl_addr, tbl_data, reg_wr, reg_key, reg_wdata,
                  output ctrl_rdata, stall);
  modport host (output tbl_wr, tbl_addr, tbl_data, reg_wr, reg_key, reg_wdata,
                input ctrl_rdata, stall);
endinterface

// ---- fss_latch_buf.sv ----
// row-wide holding latches, one word per instruction slot
`timescale 1ns/1ps
module fss_latch_buf
  import fss_pkg::*;
#(
  parameter int WORDS = FSS_ROW_WORDS
)(
  input  wire logic                 clk,
  input  wire logic                 wr_en,
  input  wire logic [FSS_IDX_W-1:0] wr_idx,
  input  wire logic [FSS_DW-1:0]    wr_data,
  input  wire logic [FSS_IDX_W-1:0] rd_idx,
  output logic      [FSS_DW-1:0]    rd_data
);
  // no reset: contents are unknown until software loads them
  logic [FSS_DW-1:0] mem [WORDS];

  // any order, later load overwrites the earlier one
  always_ff @(posedge clk)
  begin
    if (wr_en)
      mem[wr_idx] <= wr_data;
  end

  assign rd_data = mem[rd_idx];
endmodule

// ---- fss_host.sv ----
// processor-side end: wishbone registers turned into table and control writes
`timescale 1ns/1ps
module fss_host
  import fss_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        ARST_N,
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [7:0]  ADR_I,
  input  wire logic [31:0] DAT_I,
  input  wire logic [3:0]  SEL_I,
  output logic             ACK_O,
  output logic [31:0]      DAT_O,
  fss_link_if.host         link
);
  typedef enum logic [1:0] {H_IDLE, H_ISSUE, H_WAIT, H_ACK} fss_hstate_t;

  typedef struct packed {
    fss_hstate_t       st;
    logic [FSS_AW-1:0] ptr;
    logic [FSS_DW-1:0] wdata;
    logic              tbl_wr;
    logic              reg_wr;
    logic              reg_key;
    logic              ack;
    logic [31:0]       rdata;
  } fss_host_t;

  fss_host_t r;
  fss_host_t next_r;

  // bus decode and link sequencing
  always_comb
  begin
    next_r        = r;
    next_r.tbl_wr = 1'b0;
    next_r.reg_wr = 1'b0;
    next_r.ack    = 1'b0;
    case (r.st)
      H_IDLE:
      begin
        if (CYC_I && STB_I)
        begin
          next_r.rdata = 32'h00000000;
          next_r.wdata = DAT_I[FSS_DW-1:0];
          next_r.st    = H_ACK;
          next_r.ack   = 1'b1;
          if (WE_I && SEL_I != 4'h0)
          begin
            if (ADR_I == FSS_WB_PTR)
              next_r.ptr = DAT_I[FSS_AW-1:0];
            else if (ADR_I == FSS_WB_DATA)
            begin
              next_r.tbl_wr = 1'b1;
              next_r.ack    = 1'b0;
              next_r.st     = H_ISSUE;
            end
            else if (ADR_I == FSS_WB_CTRL || ADR_I == FSS_WB_KEY)
            begin
              next_r.reg_wr  = 1'b1;
              next_r.reg_key = (ADR_I == FSS_WB_KEY);
              next_r.ack     = 1'b0;
              next_r.st      = H_ISSUE;
            end
          end
          else if (!WE_I && ADR_I == FSS_WB_CTRL)
            next_r.rdata = {16'h0000, link.ctrl_rdata};
          else if (!WE_I && ADR_I == FSS_WB_PTR)
            next_r.rdata = {8'h00, r.ptr};
          else if (!WE_I && ADR_I == FSS_WB_STAT)
            next_r.rdata = {31'h00000000, link.stall};
        end
      end
      // strobe went out this cycle; device answers stall next edge
      H_ISSUE: next_r.st = H_WAIT;
      H_WAIT:
      begin
        // the bus cycle is held off exactly as the core is stalled
        if (!link.stall)
        begin
          next_r.ack = 1'b1;
          next_r.st  = H_ACK;
        end
      end
      H_ACK:   next_r.st = H_IDLE;
      default: next_r.st = H_IDLE;
    endcase
    // post-increment lets software stream a full row
    if (r.st == H_ISSUE && r.tbl_wr)
      next_r.ptr = r.ptr + 24'h000001;
  end

  // state register
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      r    <= '0;
      r.st <= H_IDLE;
    end
    else
      r <= next_r;
  end

  assign ACK_O          = r.ack;
  assign DAT_O          = r.rdata;
  assign link.tbl_wr    = r.tbl_wr;
  assign link.tbl_addr  = r.ptr;
  assign link.tbl_data  = r.wdata;
  assign link.reg_wr    = r.reg_wr;
  assign link.reg_key   = r.reg_key;
  assign link.reg_wdata = r.wdata[15:0];
endmodule

// ---- fss_link_properties.sv ----
// concurrent checks on the link between the host end and the device end
`timescale 1ns/1ps
module fss_link_properties
  import fss_pkg::*;
(
  input wire logic              CLOCK,
  input wire logic              ARST_N,
  input wire logic              tbl_wr,
  input wire logic              reg_wr,
  input wire logic              reg_key,
  input wire logic [15:0]       reg_wdata,
  input wire logic [15:0]       ctrl_rdata,
  input wire logic              stall,
  input wire logic              FLASH_PGM,
  input wire logic              FLASH_ERASE,
  input wire logic [FSS_AW-1:0] FLASH_ADDR
);
  logic [1:0] key_st;
  logic [3:0] op_q;
  logic [7:0] pgm_n;
  logic [7:0] ers_n;
  logic       k1;
  logic       k2;
  logic       go;
  // a legal start needs the key pair as the two link writes just before
  assign k1 = reg_wr && reg_key && reg_wdata[7:0] == FSS_KEY_FIRST;
  assign k2 = reg_wr && reg_key && reg_wdata[7:0] == FSS_KEY_SECOND;
  assign go = reg_wr && !reg_key && reg_wdata[15] && reg_wdata[14] && key_st == 2'd2
              && reg_wdata[3:0] inside {FSS_OP_ROW, FSS_OP_ERASE, FSS_OP_WORD};
  // unlock progress and flash pulses of the running operation
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      key_st <= 2'd0;
      op_q   <= 4'h0;
      pgm_n  <= 8'h00;
      ers_n  <= 8'h00;
    end
    else
    begin
      if (tbl_wr || reg_wr)
        key_st <= (key_st == 2'd1 && k2) ? 2'd2 : (k1 ? 2'd1 : 2'd0);
      if (go)
        op_q <= reg_wdata[3:0];
      pgm_n <= go ? 8'h00 : pgm_n + {7'h00, FLASH_PGM};
      ers_n <= go ? 8'h00 : ers_n + {7'h00, FLASH_ERASE};
    end
  end
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!ARST_N);
  property p_tbl_stall;
    tbl_wr |=> stall ##1 !stall;
  endproperty
  a_tbl_stall: assert property (p_tbl_stall)
    else $error("table write stall not one cycle");
  property p_start;
    go |=> stall && ctrl_rdata[15] ##[1:200] !stall && !ctrl_rdata[15];
  endproperty
  a_start: assert property (p_start)
    else $error("unlocked start did not run and finish");
  property p_locked;
    reg_wr && !reg_key && reg_wdata[15] && key_st != 2'd2
      |=> (!stall && !ctrl_rdata[15] && !FLASH_PGM && !FLASH_ERASE) [*3];
  endproperty
  a_locked: assert property (p_locked)
    else $error("start without unlock took effect");
  property p_busy;
    ctrl_rdata[15] |-> stall;
  endproperty
  a_busy: assert property (p_busy)
    else $error("core not stalled during operation");
  property p_quiet;
    FLASH_PGM || FLASH_ERASE |-> ctrl_rdata[15];
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("flash touched outside an operation");
  property p_row;
    $fell(ctrl_rdata[15]) && op_q == FSS_OP_ROW |-> pgm_n == 8'd64 && ers_n == 8'd0;
  endproperty
  a_row: assert property (p_row)
    else $error("row program word count wrong");
  property p_word;
    $fell(ctrl_rdata[15]) && op_q == FSS_OP_WORD |-> pgm_n == 8'd1 && ers_n == 8'd0;
  endproperty
  a_word: assert property (p_word)
    else $error("word program count wrong");
  property p_erase;
    $fell(ctrl_rdata[15]) && op_q == FSS_OP_ERASE |-> ers_n == 8'd1 && pgm_n == 8'd0;
  endproperty
  a_erase: assert property (p_erase)
    else $error("erase block count wrong");
  property p_align;
    FLASH_ERASE |-> FLASH_ADDR[8:0] == 9'h000;
  endproperty
  a_align: assert property (p_align)
    else $error("erase block not aligned");
  property p_row_addr;
    FLASH_PGM && op_q == FSS_OP_ROW |-> FLASH_ADDR[5:0] == pgm_n[5:0];
  endproperty
  a_row_addr: assert property (p_row_addr)
    else $error("row word address out of place");
endmodule

// ---- flash_self_program_sequencer_bench.sv ----
// bench driving the host end over wishbone and watching the flash side
`timescale 1ns/1ps
module flash_self_program_sequencer_bench;
  import fss_pkg::*;
  logic        clk    = 1'b0;
  logic        arst_n = 1'b0;
  logic        cyc    = 1'b0;
  logic        stb    = 1'b0;
  logic        we     = 1'b0;
  logic [7:0]  adr    = 8'h00;
  logic [31:0] wdat   = 32'h0;
  logic [3:0]  sel    = 4'h0;
  logic        ack;
  logic [31:0] rdat;
  logic        f_pgm;
  logic        f_ers;
  logic [23:0] f_addr;
  logic [23:0] f_data;
  logic [23:0] ers_a;
  logic [23:0] fmem [logic [23:0]];
  int          pgm_n, ers_n, cycles, errors, checks;
  fss_link_if i_fss_link_if ();
  fss_host i_fss_host (.CLOCK(clk), .ARST_N(arst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .DAT_I(wdat), .SEL_I(sel), .ACK_O(ack), .DAT_O(rdat), .link(i_fss_link_if));
  fss_device i_fss_device (.CLOCK(clk), .ARST_N(arst_n), .link(i_fss_link_if),
    .FLASH_PGM(f_pgm), .FLASH_ERASE(f_ers), .FLASH_ADDR(f_addr), .FLASH_DATA(f_data));
  fss_link_properties i_fss_link_properties (.CLOCK(clk), .ARST_N(arst_n),
    .tbl_wr(i_fss_link_if.tbl_wr), .reg_wr(i_fss_link_if.reg_wr),
    .reg_key(i_fss_link_if.reg_key), .reg_wdata(i_fss_link_if.reg_wdata),
    .ctrl_rdata(i_fss_link_if.ctrl_rdata), .stall(i_fss_link_if.stall),
    .FLASH_PGM(f_pgm), .FLASH_ERASE(f_ers), .FLASH_ADDR(f_addr));
  initial
    forever #20 clk = ~clk;
  // flash image and cycle ceiling; sampled before the edge's updates land
  always @(posedge clk)
  begin
    cycles++;
    if (f_pgm === 1'b1)
    begin
      fmem[f_addr] = f_data;
      pgm_n++;
    end
    if (f_ers === 1'b1)
    begin
      ers_a = f_addr;
      ers_n++;
    end
    if (cycles == 6000)
    begin
      errors++;
      give_verdict;
    end
  end
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic cycle: request held until ack is sampled high at a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hf};
    @(posedge clk);
    while (ack !== 1'b1)
      @(posedge clk);
    // read data taken at the ack edge, then the request drops for a cycle
    q = rdat;
    {cyc, stb, we} <= 3'b000;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask
  task automatic unlock;
    wr(FSS_WB_KEY, {24'h0, FSS_KEY_FIRST});
    wr(FSS_WB_KEY, {24'h0, FSS_KEY_SECOND});
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    rd(FSS_WB_CTRL, 32'hffff, {16'h0, FSS_CTRL_RESET});
    wr(8'h20, 32'hffff);
    rd(8'h20, 32'hffffffff, 32'h0);
    $display("test reset done");
    // no key, key broken by a table write, keys reversed
    for (int i = 0; i < 3; i++)
    begin
      if (i == 1)
      begin
        wr(FSS_WB_KEY, 32'h55);
        wr(FSS_WB_DATA, 32'h0);
        wr(FSS_WB_KEY, 32'haa);
      end
      if (i == 2)
      begin
        wr(FSS_WB_KEY, 32'haa);
        wr(FSS_WB_KEY, 32'h55);
      end
      wr(FSS_WB_CTRL, 32'hc001);
      rd(FSS_WB_CTRL, 32'ha000, 32'h2000);
      chk(32'(pgm_n), 32'd0);
      wr(FSS_WB_CTRL, 32'h0);
    end
    $display("test locked done");
    wr(FSS_WB_PTR, 32'h80);
    for (int i = 0; i < 64; i++)
      wr(FSS_WB_DATA, 32'h0a0000 + i);
    rd(FSS_WB_PTR, 32'hffffffff, 32'hc0);
    rd(FSS_WB_STAT, 32'h1, 32'h0);
    wr(FSS_WB_PTR, 32'h85);
    wr(FSS_WB_DATA, 32'h5b5b5b);
    unlock;
    wr(FSS_WB_CTRL, 32'hc001);
    rd(FSS_WB_CTRL, 32'ha000, 32'h0);
    chk(32'(pgm_n), 32'd64);
    for (int i = 0; i < 64; i++)
      chk({8'h0, fmem[24'(32'h80 + i)]}, (i == 5) ? 32'h5b5b5b : 32'h0a0000 + i);
    $display("test row done");
    wr(FSS_WB_PTR, 32'h200);
    wr(FSS_WB_DATA, 32'h123456);
    unlock;
    wr(FSS_WB_CTRL, 32'hc003);
    chk(32'(pgm_n), 32'd65);
    chk({8'h0, fmem[24'h200]}, 32'h123456);
    $display("test word done");
    wr(FSS_WB_PTR, 32'h4c5);
    wr(FSS_WB_DATA, 32'h0);
    unlock;
    wr(FSS_WB_CTRL, 32'hc002);
    chk(32'(ers_n), 32'd1);
    chk({8'h0, ers_a}, 32'h400);
    rd(FSS_WB_CTRL, 32'h8000, 32'h0);
    $display("test erase done");
    give_verdict;
  end
endmodule
